// ---- verilog/pdsc_regs.vh ----
`ifndef PDSC_REGS_VH
`define PDSC_REGS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PDSC_OFF_IRQ_CTRL 12'h000
`define PDSC_OFF_PERIPH_IRQ_ENABLE_1 12'h004
`define PDSC_OFF_PERIPH_IRQ_ENABLE_2 12'h008
`define PDSC_OFF_PERIPH_IRQ_FLAGS_1 12'h00C
`define PDSC_OFF_PERIPH_IRQ_FLAGS_2 12'h010
`define PDSC_OFF_PCH_FLAGS 12'h014
`define PDSC_OFF_PCH_FALL 12'h018
`define PDSC_OFF_PCH_RISE 12'h01C
`define PDSC_OFF_STATUS 12'h020
`define PDSC_OFF_WDT_CTRL 12'h024
`define PDSC_OFF_CONFIG 12'h028
`define PDSC_OFF_CORE_CMD 12'h02C
`define PDSC_OFF_STATE 12'h030
`define PDSC_OFF_WDT_CNT 12'h034
// ----------------------------------------
// field positions
// ----------------------------------------
`define PDSC_GIE_BIT 7
`define PDSC_PERIPHERAL_IRQ_ENABLE_BIT 6
`define PDSC_IRQ_CTRL_EN_MASK 8'h38
`define PDSC_TO_BIT 4
`define PDSC_PD_BIT 3
`define PDSC_SOFT_WATCHDOG_ENABLE_BIT 0
`define PDSC_CMD_SLEEP_BIT 0
`define PDSC_CMD_WATCHDOG_CLEAR_INSTR_BIT 1
`define PDSC_CFG_XTAL_BIT 2
`define PDSC_CFG_MASTER_CLEAR_PIN_BIT 3
`define PDSC_CFG_BOR_BIT 4
`define PDSC_CFG_ADC_RC_BIT 5
// ----------------------------------------
// reset values and masks
// ----------------------------------------
`define PDSC_STATUS_RST 8'h18
`define PDSC_WDT_CTRL_RST 8'h16
`define PDSC_WDT_CTRL_MASK 8'h3F
`define PDSC_PCH_MASK 8'h3F
`define PDSC_PERIPH_IRQ_ENABLE_2_MASK 8'hF8
`define PDSC_CFG_RST 8'h03
// ----------------------------------------
// watchdog modes and timing
// ----------------------------------------
`define PDSC_WDT_ON 2'h3
`define PDSC_WDT_NSLEEP 2'h2
`define PDSC_WDT_SW 2'h1
`define PDSC_OST_PERIODS 1024
`define PDSC_LF_DIV 3226
`define PDSC_IRQ_VECTOR 16'h0004
`define PDSC_DUMMY_CYCLES 2'h2
`endif

// ---- verilog/pdsc_power_down_ctrl.v ----
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pdsc_regs.vh"
// Notes on behaviour
// [R1] power-down is entered only by the sleep instruction command
// [R2] watchdog cleared on entry; keeps counting if enabled in sleep
// [R3] completed entry clears power-down flag and sets time-out flag
// [R4] cpu clock stopped in sleep; low-frequency oscillator keeps running
// [R5] timer1, sensing oscillators run; converter runs on its own rc clock
// [R6] i/o pins hold their pre-sleep state during sleep
// [R7] non-watchdog resets act normally during sleep
// [R8] master-clear, brown-out or power-on wake performs full reset
// [R9] watchdog or interrupt wake continues execution
// [R10] sleep prefetches the instruction at the next address
// [R11] interrupt wakes only if individually enabled, regardless of global enable
// [R12] global disabled: continue after sleep; enabled: next instr then service
// [R13] watchdog cleared on every wake
// [R14] interrupt pending before sleep: sleep is a no-operation, nothing changes
// [R15] interrupt during sleep: complete, wake at once, flags updated
// [R16] software tests power-down flag to detect no-operation sleep
// [R17] software may place a no-operation after sleep
// [R18] crystal mode wake waits 1024 oscillator periods
// [R19] watchdog time-out in sleep wakes, no reset, updates flags
// [R20] watchdog mode 10 runs awake and stops in sleep
// [R21] interrupt wake with global enable: two dummy cycles then vector 0x0004
module pdsc_power_down_ctrl #(
	parameter WDT_W = 24,
	parameter IO_W = 6,
	parameter OST_CYCLES = `PDSC_OST_PERIODS,
	parameter LF_DIV = `PDSC_LF_DIV
) (
	// clock and reset
	input wire i_core_clk,
	input wire i_rst_n,
	// apb
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	output reg [31:0] o_prdata,
	output reg o_pready,
	output reg o_pslverr,
	// reset sources and configuration pins
	input wire i_master_clear_pin_n,
	input wire i_brownout_reset,
	input wire i_power_on_reset,
	input wire [1:0] i_watchdog_mode_config,
	// interrupt events from peripherals and pins
	input wire [7:0] i_irq_ctrl_set,
	input wire [7:0] i_periph_irq_flags_1_set,
	input wire [7:0] i_periph_irq_flags_2_set,
	input wire [5:0] i_pin_level,
	// core and pad side
	input wire [15:0] i_core_pc,
	input wire [IO_W-1:0] i_io_out,
	input wire [IO_W-1:0] i_io_oe,
	output reg [IO_W-1:0] o_io_out,
	output reg [IO_W-1:0] o_io_oe,
	output reg o_cpu_clk_en,
	output reg o_lf_osc_en,
	output reg o_t1_osc_en,
	output reg o_sense_osc_en,
	output reg o_adc_clk_en,
	output reg o_device_reset,
	output reg [15:0] o_prefetch_addr,
	output reg o_prefetch_valid,
	output reg o_irq_vector_req,
	output reg [15:0] o_irq_vector_addr,
	output reg o_watchdog_reset,
	output reg o_sleeping
);
	localparam ST_RUN = 3'h0;
	localparam ST_SLEEP = 3'h1;
	localparam ST_OST = 3'h2;
	localparam ST_NEXT = 3'h3;
	localparam ST_DUMMY = 3'h4;
	localparam ST_RESET = 3'h5;

	// ----------------------------------------
	// functions
	// ----------------------------------------
	function wdt_active;
		input [1:0] mode;
		input swen;
		input asleep;
		begin
			case (mode)
				`PDSC_WDT_ON: wdt_active = 1'b1;
				`PDSC_WDT_NSLEEP: wdt_active = ~asleep;
				`PDSC_WDT_SW: wdt_active = swen;
				default: wdt_active = 1'b0;
			endcase
		end
	endfunction

	function [WDT_W-1:0] wdt_limit;
		input [4:0] ps;
		begin
			wdt_limit = {{(WDT_W-1){1'b0}}, 1'b1} << ps;
		end
	endfunction

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg [7:0] irq_ctrl_r;
	reg [7:0] periph_irq_enable_1_r;
	reg [7:0] periph_irq_enable_2_r;
	reg [7:0] periph_irq_flags_1_r;
	reg [7:0] periph_irq_flags_2_r;
	reg [7:0] pch_flags_r;
	reg [7:0] pch_fall_r;
	reg [7:0] pch_rise_r;
	reg [7:0] status_r;
	reg [7:0] wdt_ctrl_r;
	reg [7:0] cfg_r;
	reg [2:0] state_r;
	reg [WDT_W-1:0] wdt_cnt_r;
	reg [11:0] lf_div_r;
	reg [10:0] ost_cnt_r;
	reg [1:0] dummy_r;
	reg [15:0] sleep_pc_r;
	reg [5:0] pin_s1_r;
	reg [5:0] pin_s2_r;
	reg [5:0] pin_s3_r;
	reg [5:0] pin_stable_r;
	reg [2:0] rst_s1_r;
	reg [2:0] rst_s2_r;
	reg [2:0] rst_s3_r;
	reg rst_any_r;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	wire [2:0] rst_raw = {~i_master_clear_pin_n & cfg_r[`PDSC_CFG_MASTER_CLEAR_PIN_BIT],
		i_brownout_reset & cfg_r[`PDSC_CFG_BOR_BIT], i_power_on_reset};
	always @(posedge i_core_clk) begin
		pin_s1_r <= i_pin_level;
		pin_s2_r <= pin_s1_r;
		pin_s3_r <= pin_s2_r;
		rst_s1_r <= rst_raw;
		rst_s2_r <= rst_s1_r;
		rst_s3_r <= rst_s2_r;
	end
	wire [5:0] pin_rise = pin_s2_r & pin_s3_r & ~pin_stable_r;
	wire [5:0] pin_fall = ~pin_s2_r & ~pin_s3_r & pin_stable_r;
	wire ext_reset = |(rst_s2_r & rst_s3_r); // [R7]

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	wire acc = i_psel & i_penable & ~o_pready;
	wire wr = acc & i_pwrite;
	wire wr_cmd = wr & (i_paddr == `PDSC_OFF_CORE_CMD);
	wire sleep_cmd = wr_cmd & i_pwdata[`PDSC_CMD_SLEEP_BIT];
	wire watchdog_clear_instr_cmd = wr_cmd & i_pwdata[`PDSC_CMD_WATCHDOG_CLEAR_INSTR_BIT];
	reg [31:0] rd_nxt;
	reg hit_nxt;
	always @* begin
		hit_nxt = 1'b1;
		rd_nxt = 32'h0;
		case (i_paddr)
			`PDSC_OFF_IRQ_CTRL: rd_nxt[7:0] = irq_ctrl_r;
			`PDSC_OFF_PERIPH_IRQ_ENABLE_1: rd_nxt[7:0] = periph_irq_enable_1_r;
			`PDSC_OFF_PERIPH_IRQ_ENABLE_2: rd_nxt[7:0] = periph_irq_enable_2_r;
			`PDSC_OFF_PERIPH_IRQ_FLAGS_1: rd_nxt[7:0] = periph_irq_flags_1_r;
			`PDSC_OFF_PERIPH_IRQ_FLAGS_2: rd_nxt[7:0] = periph_irq_flags_2_r;
			`PDSC_OFF_PCH_FLAGS: rd_nxt[7:0] = pch_flags_r;
			`PDSC_OFF_PCH_FALL: rd_nxt[7:0] = pch_fall_r;
			`PDSC_OFF_PCH_RISE: rd_nxt[7:0] = pch_rise_r;
			`PDSC_OFF_STATUS: rd_nxt[7:0] = status_r;
			`PDSC_OFF_WDT_CTRL: rd_nxt[7:0] = wdt_ctrl_r;
			`PDSC_OFF_CONFIG: rd_nxt[7:0] = cfg_r;
			`PDSC_OFF_CORE_CMD: rd_nxt = 32'h0;
			`PDSC_OFF_STATE: rd_nxt[2:0] = state_r;
			`PDSC_OFF_WDT_CNT: rd_nxt[WDT_W-1:0] = wdt_cnt_r;
			default: hit_nxt = 1'b0;
		endcase
	end
	always @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h0;
		end else begin
			o_pready <= acc;
			o_pslverr <= acc & ~hit_nxt;
			o_prdata <= (acc & ~i_pwrite) ? rd_nxt : 32'h0;
		end
	end

	// ----------------------------------------
	// wake conditions
	// ----------------------------------------
	wire [7:0] pch_set_nxt = {2'b00, (pin_rise & pch_rise_r[5:0]) | (pin_fall & pch_fall_r[5:0])};
	wire pch_any = |pch_flags_r;
	wire core_irq = (irq_ctrl_r[5] & irq_ctrl_r[2]) | (irq_ctrl_r[4] & irq_ctrl_r[1]) |
		(irq_ctrl_r[3] & (irq_ctrl_r[0] | pch_any));
	wire per_irq = irq_ctrl_r[`PDSC_PERIPHERAL_IRQ_ENABLE_BIT] & (|(periph_irq_enable_1_r & periph_irq_flags_1_r) | |(periph_irq_enable_2_r & periph_irq_flags_2_r));
	wire irq_pend = core_irq | per_irq; // [R11]
	wire asleep = (state_r == ST_SLEEP);
	wire wdt_run = wdt_active(i_watchdog_mode_config, wdt_ctrl_r[`PDSC_SOFT_WATCHDOG_ENABLE_BIT], asleep); // [R20]
	// time-out on the tick that completes the full period
	wire wdt_hit = wdt_run & lf_tick & (wdt_cnt_r >= wdt_limit(wdt_ctrl_r[5:1]) - 1'b1);
	wire enter_sleep = sleep_cmd & (state_r == ST_RUN) & ~irq_pend; // [R1] [R14]
	wire wake = asleep & (irq_pend | wdt_hit); // [R9] [R15] [R19]
	wire lf_tick = (lf_div_r == 12'h000);

	// ----------------------------------------
	// sleep sequencer
	// ----------------------------------------
	always @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			state_r <= ST_RUN;
			ost_cnt_r <= 11'h0;
			dummy_r <= 2'h0;
			sleep_pc_r <= 16'h0;
			rst_any_r <= 1'b0;
		end else if (ext_reset) begin
			state_r <= ST_RESET; // [R8]
			rst_any_r <= 1'b1;
		end else begin
			case (state_r)
				ST_RUN: if (enter_sleep) begin
					state_r <= ST_SLEEP;
					sleep_pc_r <= i_core_pc + 16'h0001; // [R10]
				end
				ST_SLEEP: if (wake) begin
					ost_cnt_r <= OST_CYCLES[10:0];
					state_r <= cfg_r[`PDSC_CFG_XTAL_BIT] ? ST_OST : ST_NEXT; // [R18]
				end
				ST_OST: begin
					if (ost_cnt_r == 11'h001)
						state_r <= ST_NEXT;
					ost_cnt_r <= ost_cnt_r - 11'h001; // [R18]
				end
				ST_NEXT: begin
					dummy_r <= `PDSC_DUMMY_CYCLES;
					state_r <= (irq_pend & irq_ctrl_r[`PDSC_GIE_BIT]) ? ST_DUMMY : ST_RUN; // [R12]
				end
				ST_DUMMY: begin
					dummy_r <= dummy_r - 2'h1;
					if (dummy_r == 2'h1)
						state_r <= ST_RUN; // [R21]
				end
				ST_RESET: state_r <= ST_RUN;
				default: state_r <= ST_RUN;
			endcase
		end
	end

	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	always @(posedge i_core_clk) begin
		if (!i_rst_n || ext_reset) begin
			wdt_cnt_r <= {WDT_W{1'b0}};
			lf_div_r <= 12'h0;
			o_watchdog_reset <= 1'b0;
		end else begin
			lf_div_r <= lf_tick ? LF_DIV[11:0] - 12'h001 : lf_div_r - 12'h001;
			o_watchdog_reset <= wdt_hit & ~asleep & (state_r == ST_RUN); // [R19]
			if (enter_sleep || wake || state_r == ST_OST || watchdog_clear_instr_cmd || !wdt_run || wdt_hit)
				wdt_cnt_r <= {WDT_W{1'b0}}; // [R2] [R13]
			else if (lf_tick)
				wdt_cnt_r <= wdt_cnt_r + 1'b1; // [R2]
		end
	end

	// ----------------------------------------
	// register file
	// ----------------------------------------
	always @(posedge i_core_clk) begin
		if (!i_rst_n || ext_reset) begin
			irq_ctrl_r <= 8'h00;
			periph_irq_enable_1_r <= 8'h00;
			periph_irq_enable_2_r <= 8'h00;
			periph_irq_flags_1_r <= 8'h00;
			periph_irq_flags_2_r <= 8'h00;
			pch_flags_r <= 8'h00;
			pch_fall_r <= 8'h00;
			pch_rise_r <= 8'h00;
			status_r <= `PDSC_STATUS_RST;
			wdt_ctrl_r <= `PDSC_WDT_CTRL_RST;
			pin_stable_r <= 6'h00;
		end else begin
			pin_stable_r <= (pin_stable_r | pin_rise) & ~pin_fall;
			if (wr && i_paddr == `PDSC_OFF_IRQ_CTRL)
				irq_ctrl_r <= i_pwdata[7:0] | i_irq_ctrl_set;
			else
				irq_ctrl_r <= irq_ctrl_r | i_irq_ctrl_set;
			if (wr && i_paddr == `PDSC_OFF_PERIPH_IRQ_FLAGS_1)
				periph_irq_flags_1_r <= i_pwdata[7:0] | i_periph_irq_flags_1_set;
			else
				periph_irq_flags_1_r <= periph_irq_flags_1_r | i_periph_irq_flags_1_set;
			if (wr && i_paddr == `PDSC_OFF_PERIPH_IRQ_FLAGS_2)
				periph_irq_flags_2_r <= (i_pwdata[7:0] | i_periph_irq_flags_2_set) & `PDSC_PERIPH_IRQ_ENABLE_2_MASK;
			else
				periph_irq_flags_2_r <= (periph_irq_flags_2_r | i_periph_irq_flags_2_set) & `PDSC_PERIPH_IRQ_ENABLE_2_MASK;
			if (wr && i_paddr == `PDSC_OFF_PCH_FLAGS)
				pch_flags_r <= (i_pwdata[7:0] & pch_flags_r) | pch_set_nxt;
			else
				pch_flags_r <= pch_flags_r | pch_set_nxt;
			if (wr && i_paddr == `PDSC_OFF_PERIPH_IRQ_ENABLE_1)
				periph_irq_enable_1_r <= i_pwdata[7:0];
			if (wr && i_paddr == `PDSC_OFF_PERIPH_IRQ_ENABLE_2)
				periph_irq_enable_2_r <= i_pwdata[7:0] & `PDSC_PERIPH_IRQ_ENABLE_2_MASK;
			if (wr && i_paddr == `PDSC_OFF_PCH_FALL)
				pch_fall_r <= i_pwdata[7:0] & `PDSC_PCH_MASK;
			if (wr && i_paddr == `PDSC_OFF_PCH_RISE)
				pch_rise_r <= i_pwdata[7:0] & `PDSC_PCH_MASK;
			if (wr && i_paddr == `PDSC_OFF_WDT_CTRL)
				wdt_ctrl_r <= i_pwdata[7:0] & `PDSC_WDT_CTRL_MASK;
			if (enter_sleep) begin
				status_r[`PDSC_PD_BIT] <= 1'b0; // [R3] [R15]
				status_r[`PDSC_TO_BIT] <= 1'b1;
			end else if (wake && wdt_hit && !irq_pend) begin
				status_r[`PDSC_TO_BIT] <= 1'b0; // [R19]
			end else if (watchdog_clear_instr_cmd) begin
				status_r[`PDSC_PD_BIT] <= 1'b1;
				status_r[`PDSC_TO_BIT] <= 1'b1;
			end else if (wr && i_paddr == `PDSC_OFF_STATUS) begin
				status_r[2:0] <= i_pwdata[2:0];
			end
		end
	end

	always @(posedge i_core_clk) begin
		if (!i_rst_n)
			cfg_r <= `PDSC_CFG_RST;
		else if (wr && i_paddr == `PDSC_OFF_CONFIG)
			cfg_r <= i_pwdata[7:0];
	end

	// ----------------------------------------
	// outputs to core, pads and oscillators
	// ----------------------------------------
	always @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_io_out <= {IO_W{1'b0}};
			o_io_oe <= {IO_W{1'b0}};
			o_cpu_clk_en <= 1'b1;
			o_lf_osc_en <= 1'b1;
			o_t1_osc_en <= 1'b1;
			o_sense_osc_en <= 1'b1;
			o_adc_clk_en <= 1'b0;
			o_device_reset <= 1'b0;
			o_prefetch_addr <= 16'h0;
			o_prefetch_valid <= 1'b0;
			o_irq_vector_req <= 1'b0;
			o_irq_vector_addr <= `PDSC_IRQ_VECTOR;
			o_sleeping <= 1'b0;
		end else begin
			if (!asleep && !enter_sleep) begin
				o_io_out <= i_io_out; // [R6]
				o_io_oe <= i_io_oe;
			end
			o_cpu_clk_en <= ~(asleep | state_r == ST_OST | enter_sleep); // [R4]
			o_lf_osc_en <= 1'b1; // [R4]
			o_t1_osc_en <= 1'b1; // [R5]
			o_sense_osc_en <= 1'b1; // [R5]
			o_adc_clk_en <= cfg_r[`PDSC_CFG_ADC_RC_BIT]; // [R5]
			o_device_reset <= ext_reset | rst_any_r & (state_r == ST_RESET); // [R8]
			if (enter_sleep)
				o_prefetch_addr <= i_core_pc + 16'h0001; // [R10]
			o_prefetch_valid <= enter_sleep | (state_r == ST_NEXT); // [R12]
			o_irq_vector_req <= (state_r == ST_DUMMY) & (dummy_r == 2'h1); // [R21]
			o_irq_vector_addr <= `PDSC_IRQ_VECTOR;
			o_sleeping <= asleep | enter_sleep;
		end
	end
endmodule
`default_nettype wire

// ---- verification/pdsc_power_down_ctrl_props.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pdsc_regs.vh"
module pdsc_props #(
	parameter IO_W = 6
) (
	// clock, reset and bus
	input wire i_core_clk,
	input wire i_rst_n,
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	// core and reset side
	input wire i_power_on_reset,
	input wire [15:0] i_core_pc,
	input wire [IO_W-1:0] o_io_out,
	input wire [IO_W-1:0] o_io_oe,
	input wire o_cpu_clk_en,
	input wire o_lf_osc_en,
	input wire o_t1_osc_en,
	input wire o_sense_osc_en,
	input wire o_device_reset,
	input wire [15:0] o_prefetch_addr,
	input wire o_prefetch_valid,
	input wire o_irq_vector_req,
	input wire [15:0] o_irq_vector_addr,
	input wire o_sleeping
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_n);
	wire cmd_w = i_psel && i_penable && i_pwrite && i_paddr == `PDSC_OFF_CORE_CMD && i_pwdata[0];
	a_sleep_by_cmd: assert property ($rose(o_sleeping) |-> $past(cmd_w) || $past(cmd_w, 2))
		else $error("sleep entered without command");
	a_cpu_clk_gated: assert property (o_sleeping |-> !o_cpu_clk_en)
		else $error("cpu clock runs in sleep");
	a_osc_kept: assert property (o_lf_osc_en && o_t1_osc_en && o_sense_osc_en)
		else $error("oscillator stopped");
	a_pins_held: assert property (o_sleeping && $past(o_sleeping) |-> $stable(o_io_out) && $stable(o_io_oe))
		else $error("pad state moved in sleep");
	a_por_resets: assert property ($rose(i_power_on_reset) |-> ##[1:6] o_device_reset)
		else $error("power-on reset not seen");
	a_reset_wakes: assert property (o_device_reset |=> !o_sleeping)
		else $error("still asleep after reset");
	a_prefetch_next: assert property ($rose(o_sleeping) |-> o_prefetch_addr == i_core_pc + 16'h0001)
		else $error("prefetch address wrong");
	a_wake_resumes: assert property ($fell(o_sleeping) && !o_device_reset |-> ##[0:20] o_prefetch_valid)
		else $error("no resume after wake");
	a_vector_fetch: assert property (o_irq_vector_req |-> o_irq_vector_addr == `PDSC_IRQ_VECTOR && o_cpu_clk_en)
		else $error("vector fetch wrong");
endmodule
bind pdsc_power_down_ctrl pdsc_props #(.IO_W(IO_W)) pdsc_props_inst (.*);
`default_nettype wire

// ---- verification/pdsc_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pdsc_core_model #(
	parameter IO_W = 6,
	parameter [15:0] SLEEP_PC = 16'h0120
) (
	// clock and control
	input wire logic i_core_clk,
	input wire logic i_cpu_clk_en,
	input wire logic i_por_req,
	// core and reset lines
	output logic [15:0] o_core_pc,
	output logic [IO_W-1:0] o_io_out,
	output logic [IO_W-1:0] o_io_oe,
	output logic o_master_clear_pin_n,
	output logic o_brownout_reset,
	output logic o_power_on_reset
);
	// sleep sits at a fixed address, SLEEP_PC, the pc never moves
	assign o_core_pc = SLEEP_PC;
	assign o_master_clear_pin_n = 1'b1;
	assign o_brownout_reset = 1'b0;
	assign o_power_on_reset = i_por_req;
	initial begin
		o_io_out = '0;
		o_io_oe = '0;
	end
	// pads move every cycle, asleep too, so a missed hold shows
	always @(posedge i_core_clk) begin
		o_io_out <= o_io_out + 1'b1;
		o_io_oe <= ~o_io_oe;
	end
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pdsc_regs.vh"
module tb_top;
	// ----------------
	// signals
	// ----------------
	logic i_core_clk, i_rst_n, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
	logic [11:0] i_paddr;
	logic [31:0] i_pwdata, o_prdata, rd_q;
	logic i_master_clear_pin_n, i_brownout_reset, i_power_on_reset, por_req, rd_err;
	logic [1:0] i_watchdog_mode_config;
	logic [7:0] i_irq_ctrl_set, i_periph_irq_flags_1_set, i_periph_irq_flags_2_set;
	logic [5:0] i_pin_level, i_io_out, i_io_oe, o_io_out, o_io_oe;
	logic [15:0] i_core_pc, o_prefetch_addr, o_irq_vector_addr;
	logic o_cpu_clk_en, o_lf_osc_en, o_t1_osc_en, o_sense_osc_en, o_adc_clk_en, o_device_reset;
	logic o_prefetch_valid, o_irq_vector_req, o_watchdog_reset, o_sleeping;
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	pdsc_power_down_ctrl #(.OST_CYCLES(8), .LF_DIV(4)) pdsc_power_down_ctrl_inst (.*);
	pdsc_core_model pdsc_core_model_inst (
		.i_core_clk(i_core_clk),
		.i_cpu_clk_en(o_cpu_clk_en),
		.i_por_req(por_req),
		.o_core_pc(i_core_pc),
		.o_io_out(i_io_out),
		.o_io_oe(i_io_oe),
		.o_master_clear_pin_n(i_master_clear_pin_n),
		.o_brownout_reset(i_brownout_reset),
		.o_power_on_reset(i_power_on_reset)
	);
	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end
	// ----------------
	// helpers
	// ----------------
	task end_of_test;
		$display("compares %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			end_of_test;
		end
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] a);
		cmp_count++;
		if (a !== e) begin
			error_cnt++;
			$display("unexpected %s exp %h got %h", nm, e, a);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_core_clk);
		i_penable <= 1'b1;
		do begin
			@(posedge i_core_clk);
		end while (o_pready !== 1'b1);
		rd_q = o_prdata;
		rd_err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		@(posedge i_core_clk);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd_q);
	endtask
	task slp;
		apb(1'b1, `PDSC_OFF_CORE_CMD, 32'h1);
	endtask
	task pulse;
		i_periph_irq_flags_1_set <= 8'h01;
		@(posedge i_core_clk);
		i_periph_irq_flags_1_set <= 8'h00;
	endtask
	task wait_lo(output int n);
		n = 0;
		while (o_sleeping !== 1'b0 && n < 600) begin
			@(posedge i_core_clk);
			n++;
		end
	endtask
	// ----------------
	// scenarios
	// ----------------
	task t_regs;
		rd(`PDSC_OFF_STATUS, `PDSC_STATUS_RST, "status");
		rd(`PDSC_OFF_WDT_CTRL, `PDSC_WDT_CTRL_RST, "wdtctl");
		apb(1'b0, 12'h0FC, 32'h0);
		chk("slverr", 1, rd_err);
	endtask
	task t_noop;
		apb(1'b1, `PDSC_OFF_PERIPH_IRQ_ENABLE_1, 32'h1);
		apb(1'b1, `PDSC_OFF_IRQ_CTRL, 32'h40);
		pulse;
		slp;
		chk("asleep", 0, o_sleeping);
		rd(`PDSC_OFF_STATUS, `PDSC_STATUS_RST, "status");
		apb(1'b1, `PDSC_OFF_PERIPH_IRQ_FLAGS_1, 32'h0);
	endtask
	task t_irq;
		int n;
		slp;
		chk("asleep", 1, o_sleeping);
		rd(`PDSC_OFF_STATUS, 32'h10, "status");
		pulse;
		wait_lo(n);
		chk("woke", 1, n < 600);
		n = 0;
		repeat (10) begin
			@(posedge i_core_clk);
			if (o_irq_vector_req !== 1'b0) n++;
		end
		chk("novec", 0, n);
		apb(1'b1, `PDSC_OFF_PERIPH_IRQ_FLAGS_1, 32'h0);
	endtask
	task t_gie;
		int n;
		apb(1'b1, `PDSC_OFF_IRQ_CTRL, 32'hC0);
		slp;
		pulse;
		n = 0;
		while (o_irq_vector_req !== 1'b1 && n < 100) begin
			@(posedge i_core_clk);
			n++;
		end
		chk("vec", 1, n < 100);
		chk("vaddr", `PDSC_IRQ_VECTOR, o_irq_vector_addr);
		apb(1'b1, `PDSC_OFF_PERIPH_IRQ_FLAGS_1, 32'h0);
		apb(1'b1, `PDSC_OFF_IRQ_CTRL, 32'h40);
	endtask
	task t_ost;
		int n;
		apb(1'b1, `PDSC_OFF_CONFIG, 32'h27);
		chk("adcclk", 1, o_adc_clk_en);
		slp;
		pulse;
		n = 0;
		while (o_cpu_clk_en !== 1'b1 && n < 100) begin
			@(posedge i_core_clk);
			n++;
		end
		chk("ost", 1, n >= 8 && n < 100);
		apb(1'b1, `PDSC_OFF_CONFIG, 32'h03);
		chk("adcclk", 0, o_adc_clk_en);
		apb(1'b1, `PDSC_OFF_PERIPH_IRQ_FLAGS_1, 32'h0);
	endtask
	task t_wdt;
		int n;
		i_watchdog_mode_config <= `PDSC_WDT_ON;
		apb(1'b1, `PDSC_OFF_WDT_CTRL, 32'h0);
		slp;
		wait_lo(n);
		chk("wdtwake", 1, n < 600);
		rd(`PDSC_OFF_STATUS, 32'h00, "status");
		i_watchdog_mode_config <= `PDSC_WDT_NSLEEP;
		n = 0;
		while (o_watchdog_reset !== 1'b1 && n < 40) begin
			@(posedge i_core_clk);
			n++;
		end
		chk("wdtrst", 1, n < 40);
	endtask
	task t_por;
		int n;
		apb(1'b1, `PDSC_OFF_PERIPH_IRQ_ENABLE_1, 32'h0);
		slp;
		pulse;
		n = 0;
		repeat (60) begin
			@(posedge i_core_clk);
			if (o_sleeping !== 1'b1) n++;
		end
		chk("stayed", 0, n);
		por_req <= 1'b1;
		n = 0;
		while (o_device_reset !== 1'b1 && n < 20) begin
			@(posedge i_core_clk);
			n++;
		end
		chk("devrst", 1, n < 20);
		por_req <= 1'b0;
		repeat (8) @(posedge i_core_clk);
		chk("asleep", 0, o_sleeping);
		rd(`PDSC_OFF_STATUS, `PDSC_STATUS_RST, "status");
	endtask
	initial begin
		i_rst_n = 1'b0;
		i_psel = 1'b0;
		i_penable = 1'b0;
		i_pwrite = 1'b0;
		i_paddr = 12'h000;
		i_pwdata = 32'h0;
		i_watchdog_mode_config = 2'h0;
		i_irq_ctrl_set = 8'h00;
		i_periph_irq_flags_1_set = 8'h00;
		i_periph_irq_flags_2_set = 8'h00;
		i_pin_level = 6'h00;
		por_req = 1'b0;
		repeat (16) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		repeat (4) @(posedge i_core_clk);
		t_regs;
		t_noop;
		t_irq;
		t_gie;
		t_ost;
		t_wdt;
		t_por;
		end_of_test;
	end
endmodule
`default_nettype wire
